//--- ppm_pkg.sv
// package of constants for the port pin function mux
package ppm_pkg;
	localparam int FIRST_WIDTH  = 4;
	localparam int SECOND_WIDTH = 8;
	localparam int RTP_WIDTH    = 8;
	localparam int INV_WIDTH    = 6;
	localparam int THIRD_IDX    = 2;
	localparam int TRIG_IDX     = 3;
	localparam int SHUTOFF_IDX  = 0;
	// edge select encoding
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// reset values
	localparam logic [3:0] DIR_RST  = 4'hf;
	localparam logic [3:0] PU_RST   = 4'h0;
	localparam logic [3:0] CTL_RST  = 4'h0;
	localparam logic [7:0] EDGE_RST = 8'h00;
endpackage : ppm_pkg

//--- ppm_edge_det.sv
// per-pin synchroniser and configurable edge detector
`timescale 1ns/1ns
module ppm_edge_det (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       pin_in,
	input  wire logic [1:0] edge_sel,
	output logic            level,
	output logic            hit
);
	logic       s1_r;
	logic       s2_r;
	logic       s3_r;
	logic       hit_r;
	logic [2:0] arm_r;
	// no edges until s3 holds a real pin sample, so a high idle pin gives no false edge
	wire  armed = arm_r[2];
	wire  rise = s2_r & ~s3_r & armed;
	wire  fall = ~s2_r & s3_r & armed;
	wire  hit_nxt = ((edge_sel == ppm_pkg::EDGE_RISE) & rise) |
	                ((edge_sel == ppm_pkg::EDGE_FALL) & fall) |
	                ((edge_sel == ppm_pkg::EDGE_BOTH) & (rise | fall));
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r  <= 1'b0;
			s2_r  <= 1'b0;
			s3_r  <= 1'b0;
			arm_r <= 3'h0;
			hit_r <= 1'b0;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			arm_r <= {arm_r[1:0], 1'b1};
			hit_r <= hit_nxt;
		end
	end
	assign level = s2_r;
	assign hit   = hit_r;
endmodule : ppm_edge_det

//--- ppm_top.sv
// port pin function mux: bidirectional 4-bit port, input-only 8-bit port
`timescale 1ns/1ns
module ppm_top (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic [3:0] FIRST_PORT_PINS_IN,
	output logic      [3:0] FIRST_PORT_PINS_OUT,
	output logic      [3:0] FIRST_PORT_PINS_OE,
	output logic      [3:0] FIRST_PORT_PULLUP_EN,
	input  wire logic [3:0] FIRST_PORT_DIRECTION_REG_WDATA,
	input  wire logic [3:0] FIRST_PORT_PULLUP_REG_WDATA,
	input  wire logic [3:0] FIRST_PORT_CTL_WDATA,
	input  wire logic [3:0] FIRST_PORT_OUT_WDATA,
	input  wire logic [7:0] EDGE_SEL_WDATA,
	input  wire logic       CFG_WE,
	output logic      [3:0] FIRST_PORT_DIRECTION_REG,
	output logic      [3:0] FIRST_PORT_PULLUP_REG,
	output logic      [3:0] FIRST_PORT_CTL,
	output logic      [3:0] FIRST_PORT_READ,
	output logic      [3:0] EXT_IRQ_INPUTS_REQ,
	output logic            REALTIME_EXT_TRIG,
	output logic            CONVERTER_EXT_TRIGGER,
	output logic            INVERTER_OUTPUT_SHUTOFF,
	input  wire logic [5:0] INV_PATTERN,
	input  wire logic       INV_ENABLE,
	output logic      [5:0] INVERTER_TIMER_OUTPUTS,
	output logic      [5:0] INVERTER_TIMER_OUTPUTS_OE,
	input  wire logic [7:0] SECOND_PORT_PINS,
	output logic      [7:0] SECOND_PORT_READ,
	output logic      [7:0] CONVERTER_ANALOG_INPUTS,
	input  wire logic [7:0] RTP_DATA,
	input  wire logic       RTP_TRIGGER,
	output logic      [7:0] REALTIME_OUTPUT_PINS
);
	// ****************************************
	// configuration registers
	// ****************************************
	logic [3:0] dir_r;
	logic [3:0] pu_r;
	logic [3:0] ctl_r;
	logic [3:0] out_r;
	logic [7:0] edge_r;
	always_ff @(posedge CLK) begin
		if (RST) begin
			dir_r  <= ppm_pkg::DIR_RST;
			pu_r   <= ppm_pkg::PU_RST;
			ctl_r  <= ppm_pkg::CTL_RST;
			out_r  <= 4'h0;
			edge_r <= ppm_pkg::EDGE_RST;
		end else if (CFG_WE) begin
			dir_r  <= FIRST_PORT_DIRECTION_REG_WDATA;
			pu_r   <= FIRST_PORT_PULLUP_REG_WDATA;
			ctl_r  <= FIRST_PORT_CTL_WDATA;
			out_r  <= FIRST_PORT_OUT_WDATA;
			edge_r <= EDGE_SEL_WDATA;
		end
	end

	// ****************************************
	// first port pins and edge detectors
	// ****************************************
	logic [3:0] lvl;
	logic [3:0] hit;
	genvar g;
	generate
		for (g = 0; g < ppm_pkg::FIRST_WIDTH; g++) begin : g_pin
			ppm_edge_det u_det (
				.clk      (CLK),
				.rst      (RST),
				.pin_in   (FIRST_PORT_PINS_IN[g]),
				.edge_sel (edge_r[2*g +: 2]),
				.level    (lvl[g]),
				.hit      (hit[g])
			);
		end
	endgenerate

	// control-mode pins are inputs; dir bit 1 means input
	wire [3:0] oe_nxt   = ~ctl_r & ~dir_r;
	wire [3:0] pu_nxt   = ~ctl_r & pu_r;
	wire [3:0] irq_nxt  = ctl_r & hit;
	wire       rtt_nxt  = irq_nxt[ppm_pkg::THIRD_IDX];
	wire       adt_nxt  = ctl_r[ppm_pkg::TRIG_IDX] & hit[ppm_pkg::TRIG_IDX];
	wire       off_nxt  = ctl_r[ppm_pkg::SHUTOFF_IDX] & lvl[ppm_pkg::SHUTOFF_IDX];
	wire       drv_nxt  = INV_ENABLE & ~off_nxt;

	// ****************************************
	// second port synchroniser
	// ****************************************
	logic [7:0] sp1_r;
	logic [7:0] sp2_r;

	// ****************************************
	// output flops
	// ****************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			FIRST_PORT_PINS_OUT       <= 4'h0;
			FIRST_PORT_PINS_OE        <= 4'h0;
			FIRST_PORT_PULLUP_EN      <= 4'h0;
			FIRST_PORT_DIRECTION_REG  <= ppm_pkg::DIR_RST;
			FIRST_PORT_PULLUP_REG     <= ppm_pkg::PU_RST;
			FIRST_PORT_CTL            <= ppm_pkg::CTL_RST;
			FIRST_PORT_READ           <= 4'h0;
			EXT_IRQ_INPUTS_REQ        <= 4'h0;
			REALTIME_EXT_TRIG         <= 1'b0;
			CONVERTER_EXT_TRIGGER     <= 1'b0;
			INVERTER_OUTPUT_SHUTOFF   <= 1'b0;
			INVERTER_TIMER_OUTPUTS    <= 6'h00;
			INVERTER_TIMER_OUTPUTS_OE <= 6'h00;
			sp1_r                     <= 8'h00;
			sp2_r                     <= 8'h00;
			SECOND_PORT_READ          <= 8'h00;
			CONVERTER_ANALOG_INPUTS   <= 8'h00;
			REALTIME_OUTPUT_PINS      <= 8'h00;
		end else begin
			FIRST_PORT_PINS_OUT       <= out_r;
			FIRST_PORT_PINS_OE        <= oe_nxt;
			FIRST_PORT_PULLUP_EN      <= pu_nxt;
			FIRST_PORT_DIRECTION_REG  <= dir_r;
			FIRST_PORT_PULLUP_REG     <= pu_r;
			FIRST_PORT_CTL            <= ctl_r;
			FIRST_PORT_READ           <= lvl;
			EXT_IRQ_INPUTS_REQ        <= irq_nxt;
			REALTIME_EXT_TRIG         <= rtt_nxt;
			CONVERTER_EXT_TRIGGER     <= adt_nxt;
			INVERTER_OUTPUT_SHUTOFF   <= off_nxt;
			INVERTER_TIMER_OUTPUTS    <= drv_nxt ? INV_PATTERN : 6'h00;
			INVERTER_TIMER_OUTPUTS_OE <= {6{drv_nxt}};
			sp1_r                     <= SECOND_PORT_PINS;
			sp2_r                     <= sp1_r;
			SECOND_PORT_READ          <= sp2_r;
			CONVERTER_ANALOG_INPUTS   <= sp2_r;
			if (RTP_TRIGGER) begin
				REALTIME_OUTPUT_PINS <= RTP_DATA;
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_oe_port;
		@(posedge CLK) disable iff (RST) 1'b1 |=> FIRST_PORT_PINS_OE == $past(~ctl_r & ~dir_r);
	endproperty
	a_oe_port: assert property (p_oe_port) else $error("pin enable mismatch");
	property p_pullup;
		@(posedge CLK) disable iff (RST) ##1 (FIRST_PORT_PULLUP_EN & FIRST_PORT_CTL) == 4'h0;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pullup in control mode");
	property p_ctl_input;
		@(posedge CLK) disable iff (RST) ##1 (FIRST_PORT_PINS_OE & FIRST_PORT_CTL) == 4'h0;
	endproperty
	a_ctl_input: assert property (p_ctl_input) else $error("control pin driven");
	property p_irq;
		@(posedge CLK) disable iff (RST) EXT_IRQ_INPUTS_REQ[0] |-> $past(ctl_r[0]);
	endproperty
	a_irq: assert property (p_irq) else $error("request while in port mode");
	property p_rtt;
		@(posedge CLK) disable iff (RST) REALTIME_EXT_TRIG == EXT_IRQ_INPUTS_REQ[2];
	endproperty
	a_rtt: assert property (p_rtt) else $error("realtime trigger mismatch");
	property p_shut;
		@(posedge CLK) disable iff (RST) INVERTER_OUTPUT_SHUTOFF |-> INVERTER_TIMER_OUTPUTS_OE == 6'h00;
	endproperty
	a_shut: assert property (p_shut) else $error("inverter driving during shutoff");
	property p_rtp;
		@(posedge CLK) disable iff (RST) !$past(RTP_TRIGGER) |-> $stable(REALTIME_OUTPUT_PINS);
	endproperty
	a_rtp: assert property (p_rtp) else $error("realtime output changed without trigger");
	property p_second;
		@(posedge CLK) disable iff (RST) SECOND_PORT_READ == CONVERTER_ANALOG_INPUTS;
	endproperty
	a_second: assert property (p_second) else $error("second port paths differ");
	property p_dir_in;
		@(posedge CLK) disable iff (RST) (FIRST_PORT_DIRECTION_REG & FIRST_PORT_PINS_OE) == 4'h0;
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("input pin driven");
	property p_rtt_src;
		@(posedge CLK) disable iff (RST) REALTIME_EXT_TRIG |-> FIRST_PORT_CTL[ppm_pkg::THIRD_IDX];
	endproperty
	a_rtt_src: assert property (p_rtt_src) else $error("realtime trigger from port mode pin");
	property p_adt;
		@(posedge CLK) disable iff (RST) CONVERTER_EXT_TRIGGER |-> FIRST_PORT_CTL[ppm_pkg::TRIG_IDX];
	endproperty
	a_adt: assert property (p_adt) else $error("converter trigger from port mode pin");
	property p_shut_cut;
		@(posedge CLK) disable iff (RST)
			off_nxt |=> INVERTER_OUTPUT_SHUTOFF && (INVERTER_TIMER_OUTPUTS | INVERTER_TIMER_OUTPUTS_OE) == 6'h00;
	endproperty
	a_shut_cut: assert property (p_shut_cut) else $error("inverter outputs not cut by shutoff");
	property p_rst_out;
		@(posedge CLK) disable iff (RST) $past(RST) |->
			INVERTER_TIMER_OUTPUTS_OE == 6'h00 && FIRST_PORT_PINS_OE == 4'h0 && FIRST_PORT_PULLUP_EN == 4'h0;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("pins driven after reset");
	property p_rst_dir;
		@(posedge CLK) disable iff (RST) $past(RST) |->
			FIRST_PORT_DIRECTION_REG == ppm_pkg::DIR_RST && FIRST_PORT_PULLUP_REG == ppm_pkg::PU_RST;
	endproperty
	a_rst_dir: assert property (p_rst_dir) else $error("direction or pullup not reset");
	property p_rtp_load;
		@(posedge CLK) disable iff (RST) RTP_TRIGGER |=> REALTIME_OUTPUT_PINS == $past(RTP_DATA);
	endproperty
	a_rtp_load: assert property (p_rtp_load) else $error("realtime output not loaded on trigger");
	property p_second_sync;
		@(posedge CLK) disable iff (RST) !$past(RST) && !$past(RST, 2) && !$past(RST, 3) |->
			SECOND_PORT_READ == $past(SECOND_PORT_PINS, 3);
	endproperty
	a_second_sync: assert property (p_second_sync) else $error("second port read wrong");
endmodule : ppm_top

//--- ppm_pin_model.sv
// external pin model for the first port
`timescale 1ns/1ns
module ppm_pin_model (
	input  wire logic       tgl,
	input  wire logic [3:0] oe,
	input  wire logic [3:0] drv,
	input  wire logic [3:0] pu,
	input  wire logic [3:0] ext_en,
	input  wire logic [3:0] ext_val,
	output logic      [3:0] pins
);
	// floating line without pull-up wanders
	for (genvar i = 0; i < 4; i++) begin : g_pin
		assign pins[i] = oe[i] ? drv[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : tgl;
	end
endmodule : ppm_pin_model

//--- tb_top.sv
// self-checking bench for the port pin function mux
`timescale 1ns/1ns
module tb_top;
	logic       CLK = 1'b0, RST = 1'b1, CFG_WE = 1'b0, INV_ENABLE = 1'b0, RTP_TRIGGER = 1'b0;
	logic [3:0] FIRST_PORT_DIRECTION_REG_WDATA = 4'hf, FIRST_PORT_PULLUP_REG_WDATA = 4'h0;
	logic [3:0] FIRST_PORT_CTL_WDATA = 4'h0, FIRST_PORT_OUT_WDATA = 4'h0, ext_en = 4'hf, ext_val = 4'h0;
	logic [7:0] EDGE_SEL_WDATA = 8'h00, SECOND_PORT_PINS = 8'h00, RTP_DATA = 8'h00;
	logic [5:0] INV_PATTERN = 6'h00;
	logic [5:0] seen = 6'h00;
	logic       flt = 1'b0;
	wire  [3:0] FIRST_PORT_PINS_IN, FIRST_PORT_PINS_OUT, FIRST_PORT_PINS_OE, FIRST_PORT_PULLUP_EN;
	wire  [3:0] FIRST_PORT_DIRECTION_REG, FIRST_PORT_PULLUP_REG, FIRST_PORT_CTL, FIRST_PORT_READ;
	wire  [3:0] EXT_IRQ_INPUTS_REQ;
	wire        REALTIME_EXT_TRIG, CONVERTER_EXT_TRIGGER, INVERTER_OUTPUT_SHUTOFF;
	wire  [5:0] INVERTER_TIMER_OUTPUTS, INVERTER_TIMER_OUTPUTS_OE;
	wire  [7:0] SECOND_PORT_READ, CONVERTER_ANALOG_INPUTS, REALTIME_OUTPUT_PINS;
	int         mismatches = 0, num_checks = 0;

	ppm_top dut (.CLK, .RST, .FIRST_PORT_PINS_IN, .FIRST_PORT_PINS_OUT, .FIRST_PORT_PINS_OE,
		.FIRST_PORT_PULLUP_EN, .FIRST_PORT_DIRECTION_REG_WDATA, .FIRST_PORT_PULLUP_REG_WDATA,
		.FIRST_PORT_CTL_WDATA, .FIRST_PORT_OUT_WDATA, .EDGE_SEL_WDATA, .CFG_WE, .FIRST_PORT_DIRECTION_REG,
		.FIRST_PORT_PULLUP_REG, .FIRST_PORT_CTL, .FIRST_PORT_READ, .EXT_IRQ_INPUTS_REQ, .REALTIME_EXT_TRIG,
		.CONVERTER_EXT_TRIGGER, .INVERTER_OUTPUT_SHUTOFF, .INV_PATTERN, .INV_ENABLE, .INVERTER_TIMER_OUTPUTS,
		.INVERTER_TIMER_OUTPUTS_OE, .SECOND_PORT_PINS, .SECOND_PORT_READ, .CONVERTER_ANALOG_INPUTS,
		.RTP_DATA, .RTP_TRIGGER, .REALTIME_OUTPUT_PINS);
	ppm_pin_model u_pins (.tgl(flt), .oe(FIRST_PORT_PINS_OE), .drv(FIRST_PORT_PINS_OUT),
		.pu(FIRST_PORT_PULLUP_EN), .ext_en, .ext_val, .pins(FIRST_PORT_PINS_IN));

	always #5 CLK = ~CLK;
	// floating level wanders off the sampling edge
	always @(posedge CLK) begin
		#1;
		flt = ~flt;
	end

	// ************
	// helpers
	// ************
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : tick
	task cfg(input logic [3:0] d, p, c, o, input logic [7:0] e);
		FIRST_PORT_DIRECTION_REG_WDATA = d;
		FIRST_PORT_PULLUP_REG_WDATA = p;
		FIRST_PORT_CTL_WDATA = c;
		FIRST_PORT_OUT_WDATA = o;
		EDGE_SEL_WDATA = e;
		CFG_WE = 1'b1;
		tick(1);
		CFG_WE = 1'b0;
		tick(3);
	endtask : cfg
	task cnt(output int c);
		c = 0;
		seen = 6'h00;
		repeat (8) begin
			tick(1);
			c += $countones(EXT_IRQ_INPUTS_REQ) + REALTIME_EXT_TRIG + CONVERTER_EXT_TRIGGER;
			seen |= {CONVERTER_EXT_TRIGGER, REALTIME_EXT_TRIG, EXT_IRQ_INPUTS_REQ};
		end
	endtask : cnt
	task finish_test;
		if (mismatches == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	// ************
	// scenarios
	// ************
	task t_port;
		chk("dir", 8'h0f, FIRST_PORT_DIRECTION_REG);
		chk("pu", 8'h00, {FIRST_PORT_PULLUP_REG, FIRST_PORT_PULLUP_EN});
		chk("oe", 8'h00, {FIRST_PORT_CTL, FIRST_PORT_PINS_OE});
		chk("inv_oe", 8'h00, INVERTER_TIMER_OUTPUTS_OE);
		ext_en = 4'ha;
		ext_val = 4'h8;
		cfg(4'ha, 4'h0, 4'h0, 4'h5, 8'h00);
		tick(3);
		chk("dir_oe", 8'h05, FIRST_PORT_PINS_OE);
		chk("read", 8'h0d, FIRST_PORT_READ);
		ext_en = 4'h0;
		cfg(4'hf, 4'h5, 4'h0, 4'h0, 8'h00);
		tick(3);
		chk("pu_en", 8'h55, {FIRST_PORT_PULLUP_REG, FIRST_PORT_PULLUP_EN});
		chk("pu_rd", 8'h05, FIRST_PORT_READ & 4'h5);
	endtask : t_port
	task t_edge;
		int c;
		ext_en = 4'hf;
		ext_val = 4'h0;
		for (int m = 0; m < 4; m++) begin
			cfg(4'hf, 4'h0, 4'hf, 4'h0, {4{m[1:0]}});
			ext_val = 4'hf;
			cnt(c);
			chk("rise", m[0] ? 8'h06 : 8'h00, c[7:0]);
			ext_val = 4'h0;
			cnt(c);
			chk("fall", m[1] ? 8'h06 : 8'h00, c[7:0]);
		end
		cfg(4'hf, 4'h0, 4'h5, 4'h0, 8'hff);
		ext_val = 4'hf;
		cnt(c);
		chk("sel", 8'h03, c[7:0]);
		chk("sel_seen", 8'h15, {2'h0, seen});
		ext_val = 4'h0;
		tick(5);
	endtask : t_edge
	task t_misc;
		INV_PATTERN = 6'h2d;
		INV_ENABLE = 1'b1;
		cfg(4'he, 4'h1, 4'h1, 4'h0, 8'h00);
		chk("pu_ctl", 8'h10, {FIRST_PORT_PULLUP_REG, FIRST_PORT_PULLUP_EN});
		chk("ctl_oe", 8'h00, FIRST_PORT_PINS_OE);
		chk("inv", 8'h2d, INVERTER_TIMER_OUTPUTS);
		chk("inv_on", 8'h3f, INVERTER_TIMER_OUTPUTS_OE);
		ext_val = 4'h1;
		tick(5);
		chk("inv_off", 8'h01, {INVERTER_TIMER_OUTPUTS_OE, INVERTER_OUTPUT_SHUTOFF});
		SECOND_PORT_PINS = 8'ha5;
		tick(4);
		chk("p2", 8'ha5, SECOND_PORT_READ);
		chk("ani", 8'ha5, CONVERTER_ANALOG_INPUTS);
		RTP_DATA = 8'hc3;
		tick(2);
		chk("rtp_hold", 8'h00, REALTIME_OUTPUT_PINS);
		RTP_TRIGGER = 1'b1;
		tick(1);
		RTP_TRIGGER = 1'b0;
		tick(1);
		chk("rtp", 8'hc3, REALTIME_OUTPUT_PINS);
		RTP_DATA = 8'h18;
		tick(3);
		chk("rtp_keep", 8'hc3, REALTIME_OUTPUT_PINS);
	endtask : t_misc

	initial begin
		tick(5);
		RST = 1'b0;
		tick(1);
		t_port;
		t_edge;
		t_misc;
		finish_test;
	end
	initial begin
		#50000;
		mismatches++;
		finish_test;
	end
endmodule : tb_top
